// ==== hlsi_top.sv ====
// Top: host link interface with status port, flags and shift control
module hlsi_top (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [7:0] io_addr_in,
	input wire logic [7:0] io_wdata_in,
	input wire logic io_rd_in,
	input wire logic io_wr_in,
	output logic [7:0] io_rdata_out,
	input wire logic host_serial_data_in,
	output logic host_serial_data_out,
	output logic host_serial_data_oe_out,
	input wire logic host_error_line_in,
	output logic host_error_line_out,
	output logic host_error_line_oe_out,
	input wire logic dma_mode_line_in,
	input wire logic twelve_bit_mode_line_in,
	input wire logic host_side_ready_in,
	input wire logic host_init_in,
	input wire logic cable_backwards_in,
	input wire logic ac_ok_in,
	input wire logic rwc_error_in,
	input wire logic fill_256_in,
	output logic direction_toward_host_out,
	output logic transfer_request_flag_out,
	output logic mid_irq_out,
	output logic fill_irq_out
);
	import hlsi_pkg::*;

	logic [7:0] ctrl;
	logic treq_ff;
	logic init_held;
	logic perr_held;
	logic host_err_drive;
	logic treq_q;
	logic [8:0] fill_count;
	logic [7:0] status;
	logic [7:0] shift_data;
	logic shift_busy;
	logic shift_done;
	logic parity_bad;
	logic shift_start;
	logic emulator_reset_pulse;
	logic shift_register_clear_pulse;
	logic parity_force;
	logic transfer_request_flag;
	logic stat_hit;
	logic treq_hit;
	hlsi_state_t state;

	// Upper-nibble decode, used for both status ranges
	function automatic logic nib_hit(input logic [7:0] a,
			input logic [7:0] base);
		nib_hit = (a & HLSI_ADDR_HI_MASK) == base;
	endfunction

	// ----------------------------------------------------------------
	// Address decode and pulser
	// ----------------------------------------------------------------
	assign stat_hit = nib_hit(io_addr_in, HLSI_STAT_BASE_A) ||
		nib_hit(io_addr_in, HLSI_STAT_BASE_B);
	assign treq_hit = io_addr_in == HLSI_TREQ_PORT;
	assign emulator_reset_pulse = io_wr_in &&
		io_addr_in == HLSI_PULSE_PORT && io_wdata_in[HLSI_PU_EMU];
	assign shift_register_clear_pulse = io_wr_in &&
		io_addr_in == HLSI_PULSE_PORT && io_wdata_in[HLSI_PU_CLRSR];
	assign parity_force = io_wr_in &&
		io_addr_in == HLSI_PULSE_PORT && io_wdata_in[HLSI_PU_PSET];

	// Control latch: direction, burst length, request bit and error drive
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ctrl <= HLSI_ZERO8;
		end else if (io_wr_in && io_addr_in == HLSI_CTRL_PORT) begin
			ctrl <= io_wdata_in;
		end
	end
	assign host_err_drive = ctrl[HLSI_CT_ERRDRV];

	// Request flip-flop; a new request wins over a same-cycle clear
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			treq_ff <= 1'b0;
		end else if (treq_hit && (io_wr_in || io_rd_in)) begin
			treq_ff <= 1'b1;
		end else if (emulator_reset_pulse || shift_register_clear_pulse ||
				host_side_ready_in) begin
			treq_ff <= 1'b0;
		end
	end
	assign transfer_request_flag = treq_ff || ctrl[HLSI_CT_TREQ];

	// Held initialize flag; the host pulse wins over a clear
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			init_held <= 1'b0;
		end else if (host_init_in) begin
			init_held <= 1'b1;
		end else if (emulator_reset_pulse) begin
			init_held <= 1'b0;
		end
	end

	// Parity error stays until the emulator reset; pulser can force it
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			perr_held <= 1'b0;
		end else if (parity_bad || parity_force) begin
			perr_held <= 1'b1;
		end else if (emulator_reset_pulse) begin
			perr_held <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// Shift sequencer: waits for the flag to fall, then bursts
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			state <= HLSI_IDLE;
		end else if (emulator_reset_pulse) begin
			state <= HLSI_IDLE;
		end else begin
			case (state)
				HLSI_IDLE: begin
					if (transfer_request_flag) begin
						state <= HLSI_WAIT;
					end
				end
				HLSI_WAIT: begin
					if (!transfer_request_flag) begin
						state <= HLSI_SHIFT;
					end
				end
				HLSI_SHIFT: begin
					if (shift_done) begin
						state <= HLSI_IDLE;
					end
				end
				default: begin
					state <= HLSI_IDLE;
				end
			endcase
		end
	end
	// Start only on entry, so one burst per request
	assign shift_start = state == HLSI_SHIFT && !shift_busy && !shift_done;

	hlsi_shifter u_shift (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.clear_in(emulator_reset_pulse),
		.start_in(shift_start),
		.sel8_in(ctrl[HLSI_CT_SEL8]),
		.toward_host_in(!ctrl[HLSI_CT_DIR]),
		.load_in(io_wr_in && treq_hit),
		.load_data_in(io_wdata_in),
		.serial_in(host_serial_data_in),
		.serial_out(host_serial_data_out),
		.data_out(shift_data),
		.busy_out(shift_busy),
		.done_out(shift_done),
		.parity_bad_out(parity_bad)
	);

	// Fill/empty counter counts rising edges of the request flag
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			treq_q <= 1'b0;
			fill_count <= 9'h000;
			fill_irq_out <= 1'b0;
		end else begin
			treq_q <= transfer_request_flag;
			fill_irq_out <= 1'b0;
			if (transfer_request_flag && !treq_q) begin
				if (fill_count + 9'h001 ==
						(fill_256_in ? HLSI_FILL_256 : HLSI_FILL_128)) begin
					fill_count <= 9'h000;
					fill_irq_out <= 1'b1;
				end else begin
					fill_count <= fill_count + 9'h001;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Status word and read data
	// ----------------------------------------------------------------
	always_comb begin
		status = HLSI_ZERO8;
		status[HLSI_ST_BKWRDS] = cable_backwards_in;
		status[HLSI_ST_IFERR] = host_error_line_in;
		status[HLSI_ST_ACOK] = ac_ok_in;
		status[HLSI_ST_DMA] = dma_mode_line_in;
		status[HLSI_ST_TWELVE] = twelve_bit_mode_line_in;
		status[HLSI_ST_INIT] = init_held;
		status[HLSI_ST_PERR] = perr_held;
		status[HLSI_ST_RDY] = host_side_ready_in;
	end

	// Read data registered one cycle after the read strobe
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			io_rdata_out <= HLSI_ZERO8;
		end else if (io_rd_in && stat_hit) begin
			io_rdata_out <= status;
		end else if (io_rd_in && (treq_hit ||
				io_addr_in == HLSI_DATA_PORT)) begin
			io_rdata_out <= shift_data;
		end else begin
			io_rdata_out <= HLSI_ZERO8;
		end
	end

	// Mid-priority interrupt from any of the three error sources
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			mid_irq_out <= 1'b0;
		end else begin
			mid_irq_out <= perr_held || init_held || rwc_error_in;
		end
	end

	// Pin drives: data drives only while sending toward the host
	assign host_serial_data_oe_out = !ctrl[HLSI_CT_DIR] && shift_busy;
	assign host_error_line_out = 1'b1;
	assign host_error_line_oe_out = host_err_drive;
	assign direction_toward_host_out = ctrl[HLSI_CT_DIR];
	assign transfer_request_flag_out = transfer_request_flag;
endmodule

// ==== hlsi_pkg.sv ====
// Package: constants for the host link shift interface
package hlsi_pkg;
	// Processor port address decode (upper nibble)
	localparam logic [7:0] HLSI_STAT_BASE_A = 8'ha0;
	localparam logic [7:0] HLSI_STAT_BASE_B = 8'hb0;
	localparam logic [7:0] HLSI_ADDR_HI_MASK = 8'hf0;
	// Data, transfer-request, control and pulse ports (our choice)
	localparam logic [7:0] HLSI_DATA_PORT = 8'h90;
	localparam logic [7:0] HLSI_TREQ_PORT = 8'h98;
	localparam logic [7:0] HLSI_CTRL_PORT = 8'hd0;
	localparam logic [7:0] HLSI_PULSE_PORT = 8'hd8;
	// Status bit positions
	localparam int HLSI_ST_BKWRDS = 0;
	localparam int HLSI_ST_IFERR = 1;
	localparam int HLSI_ST_ACOK = 2;
	localparam int HLSI_ST_DMA = 3;
	localparam int HLSI_ST_TWELVE = 4;
	localparam int HLSI_ST_INIT = 5;
	localparam int HLSI_ST_PERR = 6;
	localparam int HLSI_ST_RDY = 7;
	// Control latch bits
	localparam int HLSI_CT_DIR = 0;
	localparam int HLSI_CT_SEL8 = 1;
	localparam int HLSI_CT_ERRDRV = 2;
	localparam int HLSI_CT_TREQ = 7;
	// Pulse port bits
	localparam int HLSI_PU_EMU = 0;
	localparam int HLSI_PU_CLRSR = 1;
	localparam int HLSI_PU_PSET = 2;
	// Burst lengths and fill counter limits
	localparam logic [3:0] HLSI_BURST_4 = 4'h4;
	localparam logic [3:0] HLSI_BURST_8 = 4'h8;
	localparam logic [8:0] HLSI_FILL_128 = 9'h080;
	localparam logic [8:0] HLSI_FILL_256 = 9'h100;
	localparam logic [7:0] HLSI_ZERO8 = 8'h00;
	// Shift sequencer states
	typedef enum logic [2:0] {
		HLSI_IDLE = 3'h1,
		HLSI_WAIT = 3'h2,
		HLSI_SHIFT = 3'h4
	} hlsi_state_t;
endpackage

// ==== hlsi_shifter.sv ====
// Shift-pulse generator with bidirectional shift register and parity
module hlsi_shifter (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic clear_in,
	input wire logic start_in,
	input wire logic sel8_in,
	input wire logic toward_host_in,
	input wire logic load_in,
	input wire logic [7:0] load_data_in,
	input wire logic serial_in,
	output logic serial_out,
	output logic [7:0] data_out,
	output logic busy_out,
	output logic done_out,
	output logic parity_bad_out
);
	import hlsi_pkg::*;

	logic [3:0] count;
	logic [3:0] next_count;
	logic parity;

	// Preload picks four or eight pulses per burst
	always_comb begin
		next_count = sel8_in ? HLSI_BURST_8 : HLSI_BURST_4;
	end

	// ----------------------------------------------------------------
	// Pulse counter
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			count <= 4'h0;
		end else if (clear_in) begin
			count <= 4'h0;
		end else if (start_in && count == 4'h0) begin
			count <= next_count;
		end else if (count != 4'h0) begin
			count <= count - 4'h1;
		end
	end

	// Register shifts one bit per pulse; direction follows the latch
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			data_out <= 8'h00;
		end else if (clear_in) begin
			data_out <= 8'h00;
		end else if (load_in) begin
			data_out <= load_data_in;
		end else if (count != 4'h0) begin
			if (toward_host_in) begin
				data_out <= {data_out[6:0], 1'b0};
			end else begin
				data_out <= {serial_in, data_out[7:1]};
			end
		end
	end

	// Running parity of every bit taken in from the host
	always_ff @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			parity <= 1'b0;
		end else if (clear_in || (start_in && count == 4'h0)) begin
			parity <= 1'b0;
		end else if (count != 4'h0 && !toward_host_in) begin
			parity <= parity ^ serial_in;
		end
	end

	// Outgoing bit is the register MSB; odd parity expected on receive
	assign serial_out = data_out[7];
	assign busy_out = (count != 4'h0);
	assign done_out = (count == 4'h1);
	assign parity_bad_out = done_out && !toward_host_in &&
		!(parity ^ serial_in);
endmodule

// ==== hlsi_host_model.sv ====
// Host-side link partner: ready handshake, serial source, burst count
module hlsi_host_model (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic flag_in,
	input wire logic en_in,
	input wire logic slow_in,
	input wire logic oe_in,
	output logic ready_out,
	output logic data_out,
	output int tx_count_out
);
	timeunit 1ns;
	timeprecision 1ps;
	int dly;
	int win;
	logic tgl;
	// ----------------------------------------
	// Handshake: ready only with a request pending
	// ----------------------------------------
	always @(posedge sys_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ready_out <= 1'b0;
			dly <= 0;
			win <= 0;
			tgl <= 1'b0;
			tx_count_out <= 0;
		end else begin
			tgl <= ~tgl;
			tx_count_out <= tx_count_out + int'(oe_in);
			dly <= (flag_in && en_in) ? dly + 1 : 0;
			// Held until the flag falls, then released at once
			if (ready_out && !flag_in) begin
				ready_out <= 1'b0;
			end else if (flag_in && en_in && dly >= (slow_in ? 5 : 0)) begin
				ready_out <= 1'b1;
			end
			win <= (ready_out && !flag_in) ? 16 : (win != 0 ? win - 1 : 0);
		end
	end
	// Word held as ones while shifting; a moving pattern when released
	assign data_out = (win != 0) ? 1'b1 : tgl;
endmodule

// ==== hlsi_top_chk.sv ====
// Checker: port-level properties of the host link interface
module hlsi_top_chk import hlsi_pkg::*; (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [7:0] io_addr_in,
	input wire logic [7:0] io_wdata_in,
	input wire logic io_rd_in,
	input wire logic io_wr_in,
	input wire logic [7:0] io_rdata_out,
	input wire logic dma_mode_line_in,
	input wire logic twelve_bit_mode_line_in,
	input wire logic host_init_in,
	input wire logic host_serial_data_oe_out,
	input wire logic host_error_line_out,
	input wire logic host_error_line_oe_out,
	input wire logic direction_toward_host_out,
	input wire logic transfer_request_flag_out,
	input wire logic mid_irq_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (rst_in);
	logic wr_ctl;
	// Control latch write strobe
	assign wr_ctl = io_wr_in && io_addr_in == HLSI_CTRL_PORT;
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_status_read: assert property (
		io_rd_in && io_addr_in[7:5] == 3'h5 |=> io_rdata_out[4:3] ==
		$past({twelve_bit_mode_line_in, dma_mode_line_in}))
		else $error("status lines not shown");
	a_unmapped_zero: assert property (
		io_rd_in && io_addr_in == 8'h00 |=> io_rdata_out == 8'h00)
		else $error("unmapped read not zero");
	a_req_set: assert property (
		io_wr_in && io_addr_in == HLSI_TREQ_PORT |=> transfer_request_flag_out)
		else $error("request flag not set");
	a_ctl_req: assert property (
		wr_ctl && io_wdata_in[7] |=> transfer_request_flag_out)
		else $error("latch bit did not raise flag");
	a_dir_latch: assert property (
		wr_ctl |=> direction_toward_host_out == $past(io_wdata_in[0]))
		else $error("direction not latched");
	a_err_enable: assert property (
		wr_ctl |=> host_error_line_oe_out == $past(io_wdata_in[2]))
		else $error("error line enable wrong");
	a_oe_dir: assert property (
		host_serial_data_oe_out |-> !direction_toward_host_out
		&& host_error_line_out)
		else $error("data driven against direction");
	a_init_irq: assert property (
		host_init_in |-> ##[1:3] mid_irq_out)
		else $error("no interrupt after initialize");
	a_burst_min: assert property (
		$rose(host_serial_data_oe_out) |-> host_serial_data_oe_out[*4])
		else $error("burst shorter than four");
	c_burst: cover property ($rose(host_serial_data_oe_out));
	c_irq: cover property ($rose(mid_irq_out));
	c_req: cover property ($fell(transfer_request_flag_out));
endmodule

// ==== hlsi_top_test.sv ====
// Testbench: host link interface against a host model and scoreboard
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin \
	miscompares++; $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module hlsi_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import hlsi_pkg::*;
	logic sys_clk_in = 0, rst_in = 1, io_rd_in = 0, io_wr_in = 0;
	logic [7:0] io_addr_in = 0, io_wdata_in = 0, io_rdata_out, v;
	logic host_serial_data_in, host_serial_data_out, host_serial_data_oe_out;
	logic host_error_line_in, host_error_line_out, host_error_line_oe_out;
	logic dma_mode_line_in = 0, twelve_bit_mode_line_in = 0, host_init_in = 0;
	logic cable_backwards_in = 0, ac_ok_in = 1, rwc_error_in = 0;
	logic fill_256_in = 0, host_side_ready_in, hdata, err_drv = 1;
	logic direction_toward_host_out, transfer_request_flag_out;
	logic mid_irq_out, fill_irq_out, en = 1, slow = 0;
	bit perr, init_h, ctl_err;
	int miscompares = 0, comparisons = 0, cycles = 0, txc, n;
	int rises = 0, fills = 0;
	bit flag_q, irq_exp;
	logic [7:0] w, rx, sent_q[$];
	// Wire levels seen by both ends of the link
	assign host_serial_data_in = host_serial_data_oe_out ?
		host_serial_data_out : hdata;
	assign host_error_line_in = host_error_line_oe_out ?
		host_error_line_out : err_drv;
	always #2 sys_clk_in = ~sys_clk_in;
	hlsi_top hlsi_top_i (.sys_clk_in, .rst_in, .io_addr_in, .io_wdata_in,
		.io_rd_in, .io_wr_in, .io_rdata_out, .host_serial_data_in,
		.host_serial_data_out, .host_serial_data_oe_out, .host_error_line_in,
		.host_error_line_out, .host_error_line_oe_out, .dma_mode_line_in,
		.twelve_bit_mode_line_in, .host_side_ready_in, .host_init_in,
		.cable_backwards_in, .ac_ok_in, .rwc_error_in, .fill_256_in,
		.direction_toward_host_out, .transfer_request_flag_out, .mid_irq_out,
		.fill_irq_out);
	hlsi_host_model hlsi_host_model_i (.sys_clk_in, .rst_in,
		.flag_in(transfer_request_flag_out), .en_in(en), .slow_in(slow),
		.oe_in(host_serial_data_oe_out), .ready_out(host_side_ready_in),
		.data_out(hdata), .tx_count_out(txc));
	// ----------------------------------------
	// Port cycles and scoreboard
	// ----------------------------------------
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk_in);
		io_addr_in <= a;
		io_wdata_in <= d;
		io_wr_in <= 1'b1;
		@(posedge sys_clk_in);
		io_wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk_in);
		io_addr_in <= a;
		io_rd_in <= 1'b1;
		@(posedge sys_clk_in);
		io_rd_in <= 1'b0;
		#1 d = io_rdata_out;
	endtask
	// Expected status built from the model's own flags
	task automatic st(input logic [7:0] a);
		logic [7:0] e;
		e = {host_side_ready_in, perr, init_h, twelve_bit_mode_line_in,
			dma_mode_line_in, ac_ok_in, ctl_err | err_drv, cable_backwards_in};
		rd(a, v);
		`CHK(v, e)
	endtask
	// Bounded wait for the flag to drop, then room for a burst
	task automatic settle();
		for (int i = 0; i < 40 && transfer_request_flag_out !== 1'b0; i++)
			@(posedge sys_clk_in);
		repeat (16) @(posedge sys_clk_in);
	endtask
	task summarize();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Far-end capture of the bits the design sends toward the host
	always @(posedge sys_clk_in) begin
		if (host_serial_data_oe_out) begin
			rx <= {rx[6:0], host_serial_data_in};
		end
	end
	// Fill counter model: a pulse follows every 128th rise of the flag
	always @(posedge sys_clk_in) begin
		if (!rst_in) begin
			`CHK(fill_irq_out, irq_exp)
			fills += int'(fill_irq_out);
		end
		flag_q <= transfer_request_flag_out;
		irq_exp <= 1'b0;
		if (transfer_request_flag_out && !flag_q) begin
			rises++;
			irq_exp <= (rises % 128 == 0);
		end
	end
	// Hang guard: whole run needs about a thousand cycles
	always @(posedge sys_clk_in) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			summarize();
		end
	end
	initial begin
		void'($urandom(32'h0310));
		repeat (8) @(posedge sys_clk_in);
		rst_in <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			v = 8'($urandom);
			dma_mode_line_in <= v[0];
			twelve_bit_mode_line_in <= v[1];
			cable_backwards_in <= v[2];
			ac_ok_in <= v[3];
			err_drv <= v[4];
			ctl_err = i[0];
			wr(HLSI_CTRL_PORT, {5'h0, ctl_err, 2'h1});
			st({3'h5, 5'($urandom)});
		end
		rd(8'h00, v);
		`CHK(v, 8'h00)
		$display("status test done");
		@(posedge sys_clk_in) host_init_in <= 1'b1;
		@(posedge sys_clk_in) host_init_in <= 1'b0;
		init_h = 1;
		repeat (3) @(posedge sys_clk_in);
		#1 `CHK(mid_irq_out, 1'b1)
		st(HLSI_STAT_BASE_A);
		wr(HLSI_PULSE_PORT, 8'h01);
		init_h = 0;
		st(HLSI_STAT_BASE_B);
		wr(HLSI_PULSE_PORT, 8'h04);
		perr = 1;
		st(HLSI_STAT_BASE_A);
		wr(HLSI_PULSE_PORT, 8'h01);
		perr = 0;
		st(HLSI_STAT_BASE_B);
		#1 `CHK(mid_irq_out, 1'b0)
		@(posedge sys_clk_in) rwc_error_in <= 1'b1;
		repeat (2) @(posedge sys_clk_in);
		#1 `CHK(mid_irq_out, 1'b1)
		@(posedge sys_clk_in) rwc_error_in <= 1'b0;
		$display("flag test done");
		ctl_err = 0;
		for (int k = 0; k < 4; k++) begin
			slow = k[0];
			wr(HLSI_CTRL_PORT, {6'h0, k[1], 1'b0});
			n = txc;
			w = 8'($urandom);
			sent_q.push_back(w);
			wr(HLSI_TREQ_PORT, w);
			#1 `CHK(transfer_request_flag_out, 1'b1)
			settle();
			`CHK(txc - n, k[1] ? 8 : 4)
			// Host sees the word MSB first; a short burst gives the top half
			w = sent_q.pop_front();
			if (!k[1])
				w = {4'h0, w[7:4]};
			`CHK((k[1] ? rx : {4'h0, rx[3:0]}), w)
			wr(HLSI_CTRL_PORT, {6'h0, k[1], 1'b1});
			rd(HLSI_TREQ_PORT, v);
			settle();
			rd(HLSI_DATA_PORT, v);
			if (k[1])
				`CHK(v, 8'hff)
			perr = ((k[1] ? 8 : 4) % 2 == 0);
			st(HLSI_STAT_BASE_A);
			wr(HLSI_PULSE_PORT, 8'h01);
			perr = 0;
		end
		$display("transfer test done");
		en = 0;
		wr(HLSI_CTRL_PORT, 8'h81);
		#1 `CHK(transfer_request_flag_out, 1'b1)
		wr(HLSI_CTRL_PORT, 8'h01);
		wr(HLSI_TREQ_PORT, 8'h00);
		wr(HLSI_PULSE_PORT, 8'h02);
		#1 `CHK(transfer_request_flag_out, 1'b0)
		// Latch bit raises the flag 128 times to run the fill counter over
		repeat (128) begin
			wr(HLSI_CTRL_PORT, 8'h81);
			wr(HLSI_CTRL_PORT, 8'h01);
		end
		repeat (2) @(posedge sys_clk_in);
		`CHK(fills, rises / 128)
		$display("fill test done");
		en = 1;
		$display("request test done");
		summarize();
	end
endmodule
bind hlsi_top hlsi_top_chk hlsi_top_chk_i (.sys_clk_in, .rst_in, .io_addr_in,
	.io_wdata_in, .io_rd_in, .io_wr_in, .io_rdata_out, .dma_mode_line_in,
	.twelve_bit_mode_line_in, .host_init_in, .host_serial_data_oe_out,
	.host_error_line_out, .host_error_line_oe_out,
	.direction_toward_host_out, .transfer_request_flag_out, .mid_irq_out);
